// ==== logic/tcp_consts.svh ====
// Register indices, field positions, reset values and bus codes
`ifndef TCP_CONSTS_SVH
`define TCP_CONSTS_SVH

// Register index; byte address is four times the index
`define TCP_IDX_CS0      6'h25
`define TCP_IDX_VH0      6'h26
`define TCP_IDX_VL0      6'h27
`define TCP_IDX_CS1      6'h28
`define TCP_IDX_VH1      6'h29
`define TCP_IDX_VL1      6'h2a

// Register kinds inside the decode result
`define TCP_KIND_CS      2'h0
`define TCP_KIND_HI      2'h1
`define TCP_KIND_LO      2'h2

// Channel control/status fields
`define TCP_CS_FLAG      7
`define TCP_CS_IE        6
`define TCP_CS_MSB       5
`define TCP_CS_MSA       4
`define TCP_CS_ELSH      3
`define TCP_CS_ELSL      2
`define TCP_CS_TGLOVF    1
`define TCP_CS_MAX       0

// Reset values and write masks
`define TCP_CS_RESET     8'h00
`define TCP_VAL_RESET    16'h0000
`define TCP_CS_WMASK0    7'h7f
`define TCP_CS_WMASK1    7'h5f

// Bus responses
`define TCP_RESP_OKAY    2'h0
`define TCP_RESP_SLVERR  2'h2

`endif

// ==== logic/tcp_pkg.sv ====
// Types shared by the channel logic and its register block
package tcp_pkg;

   typedef logic [15:0] tcp_count_t;

   // Edge/level code: port control, then the three active codes
   typedef enum logic [1:0] {
      tcp_act_port,
      tcp_act_toggle,
      tcp_act_clear,
      tcp_act_set
   } tcp_els_t;

endpackage

// ==== logic/tcp_chan.sv ====
// One timer channel: input capture, output compare and PWM pin
`timescale 1ns/10ps

module tcp_chan (
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // Channel settings
   input  wire logic              mode_select_b,
   input  wire logic              mode_select_a,
   input  wire logic [1:0]        edge_level_select,
   input  wire logic              toggle_on_overflow,
   input  wire logic              force_full_duty,
   input  wire tcp_pkg::tcp_count_t cmp_val,
   // Shared counter
   input  wire tcp_pkg::tcp_count_t cnt,
   input  wire logic              ovf,
   // Pin
   input  wire logic              pin_in,
   output      logic              pin_out,
   output      logic              pin_oe_n,
   // Events
   output      logic              cap_evt,
   output      tcp_pkg::tcp_count_t cap_val,
   output      logic              cmp_evt
);

   tcp_pkg::tcp_els_t act;
   logic              cap_mode;
   logic              out_mode;
   logic              match;
   logic              edge_hit;
   logic              pin_prev;
   logic              full_q;
   logic              act_lvl;

   assign act      = tcp_pkg::tcp_els_t'(edge_level_select);
   assign cap_mode = !mode_select_b && !mode_select_a
                     && act != tcp_pkg::tcp_act_port;
   assign out_mode = (mode_select_b || mode_select_a)
                     && act != tcp_pkg::tcp_act_port;
   assign match    = out_mode && cnt == cmp_val;
   // Pulse level driven from the start of each period
   assign act_lvl  = act != tcp_pkg::tcp_act_set;
   // Assumes the pin was stable before capture was enabled
   assign edge_hit = (edge_level_select[0] && pin_in && !pin_prev)
                     || (edge_level_select[1] && !pin_in && pin_prev);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_prev <= 1'b0;
      end else begin
         pin_prev <= pin_in;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cap_evt <= 1'b0;
         cap_val <= 16'h0000;
      end else begin
         cap_evt <= cap_mode && edge_hit;
         if (cap_mode && edge_hit) begin
            cap_val <= cnt;
         end
      end
   end

   // Full duty changes only at a period boundary
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         full_q <= 1'b0;
      end else if (ovf) begin
         full_q <= force_full_duty && !toggle_on_overflow;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmp_evt <= 1'b0;
      end else begin
         cmp_evt <= match;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_out  <= 1'b1;
         pin_oe_n <= 1'b1;
      end else begin
         pin_oe_n <= !out_mode;
         if (!out_mode) begin
            pin_out <= !mode_select_a;
         end else if (ovf && toggle_on_overflow) begin
            pin_out <= !pin_out;
         end else if (full_q) begin
            pin_out <= act_lvl;
         end else if (ovf && act != tcp_pkg::tcp_act_toggle) begin
            pin_out <= act_lvl;
         end else if (match) begin
            case (act)
               tcp_pkg::tcp_act_toggle: pin_out <= !pin_out;
               tcp_pkg::tcp_act_clear:  pin_out <= 1'b0;
               tcp_pkg::tcp_act_set:    pin_out <= 1'b1;
               default:                 pin_out <= pin_out;
            endcase
         end
      end
   end

   AST_CAP_LATCH: assert property (@(posedge aclk) disable iff (!aresetn)
      cap_mode && edge_hit |=> cap_evt && cap_val == $past(cnt))
      else $error("capture did not latch counter");

   AST_FALL_ONLY: assert property (@(posedge aclk) disable iff (!aresetn)
      cap_mode && act == tcp_pkg::tcp_act_clear && pin_in && !pin_prev
      |=> !cap_evt)
      else $error("falling-edge capture fired on rising edge");

   AST_PRESET: assert property (@(posedge aclk) disable iff (!aresetn)
      !out_mode |=> pin_oe_n && pin_out == !$past(mode_select_a))
      else $error("port-control preset level wrong");

   AST_TOV_TOGGLE: assert property (@(posedge aclk) disable iff (!aresetn)
      out_mode && toggle_on_overflow && ovf |=> pin_out != $past(pin_out))
      else $error("overflow toggle missing");

   AST_CLEAR_CMP: assert property (@(posedge aclk) disable iff (!aresetn)
      match && act == tcp_pkg::tcp_act_clear && !ovf && !full_q
      |=> !pin_out && !pin_oe_n)
      else $error("clear on compare failed");

   AST_SET_BUF: assert property (@(posedge aclk) disable iff (!aresetn)
      mode_select_b && match && act == tcp_pkg::tcp_act_set && !ovf
      && !full_q |=> pin_out)
      else $error("buffered set on compare failed");

   AST_FULL_DUTY: assert property (@(posedge aclk) disable iff (!aresetn)
      full_q && out_mode && !toggle_on_overflow |=> pin_out == $past(act_lvl))
      else $error("full duty level not held");

   AST_MAX_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
      !ovf |=> full_q == $past(full_q))
      else $error("full duty changed inside a period");

   AST_PERIOD_START: assert property (@(posedge aclk) disable iff (!aresetn)
      out_mode && ovf && !toggle_on_overflow && !full_q
      && act == tcp_pkg::tcp_act_clear |=> pin_out)
      else $error("period start level wrong");

   COV_CAPTURE: cover property (@(posedge aclk) disable iff (!aresetn)
      cap_mode ##1 cap_evt);
   COV_FULL: cover property (@(posedge aclk) disable iff (!aresetn)
      full_q && out_mode);

endmodule

// ==== logic/tcp_top.sv ====
// Timer channel pair with capture, compare, PWM and AXI4-Lite registers
`timescale 1ns/10ps
`include "tcp_consts.svh"

// Summary of operation
// - Channels 0 and 1 pair; output on pin 0
// - Link bit pairs channels; channel 0 first
// - Channel 1 write takes over next period
// - Each overflow selects the last written set
// - Edge/level 00: port control, preset level
// - Capture modes: rising, falling or both edges
// - Compare: toggle, clear or set pin
// - Buffered compare uses same three actions
// - Toggle-on-overflow inverts pin at each overflow
// - Overflow action beats same-cycle compare action
// - Full-duty bit forces 100% PWM output unless toggle-on-overflow is set
// - Full-duty change applies from next period
// - Compare flag at pulse end; overflow outside
module tcp_top (
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // AXI4-Lite write
   input  wire logic [7:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output      logic              s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output      logic              s_axi_wready,
   output      logic [1:0]        s_axi_bresp,
   output      logic              s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // AXI4-Lite read
   input  wire logic [7:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output      logic              s_axi_arready,
   output      logic [31:0]       s_axi_rdata,
   output      logic [1:0]        s_axi_rresp,
   output      logic              s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Shared counter
   input  wire tcp_pkg::tcp_count_t tmr_count,
   input  wire logic              tmr_overflow,
   // Channel pins
   input  wire logic              channel0_pin_in,
   output      logic              channel0_pin_out,
   output      logic              channel0_pin_oe_n,
   input  wire logic              channel1_pin_in,
   output      logic              channel1_pin_out,
   output      logic              channel1_pin_oe_n,
   // Channel event requests
   output      logic [1:0]        chan_req
);

   logic [7:0]          ctl [2];
   tcp_pkg::tcp_count_t val [2];
   tcp_pkg::tcp_count_t cmp [2];
   tcp_pkg::tcp_count_t cap_val [2];
   logic [1:0]          cap_evt;
   logic [1:0]          cmp_evt;
   logic [1:0]          pin_in;
   logic [1:0]          pin_out;
   logic [1:0]          pin_oe_n;
   logic [1:0]          val_wr;
   logic                link;
   logic                link_q;
   logic                src_active;
   logic                src_pending;

   logic                aw_held;
   logic                w_held;
   logic                next_aw_held;
   logic                next_w_held;
   logic                next_bvalid;
   logic                next_rvalid;
   logic                wr_go;
   logic [7:0]          aw_addr;
   logic [7:0]          w_data;
   logic                w_lane0;
   logic [3:0]          wsel;
   logic [3:0]          rsel;
   logic [7:0]          rd_byte;

   // Decode: {hit, channel, kind[1:0]}
   function automatic logic [3:0] reg_sel(input logic [7:0] addr);
      reg_sel = 4'h0;
      if (addr[1:0] == 2'h0) begin
         case (addr[7:2])
            `TCP_IDX_CS0: reg_sel = {2'b10, `TCP_KIND_CS};
            `TCP_IDX_VH0: reg_sel = {2'b10, `TCP_KIND_HI};
            `TCP_IDX_VL0: reg_sel = {2'b10, `TCP_KIND_LO};
            `TCP_IDX_CS1: reg_sel = {2'b11, `TCP_KIND_CS};
            `TCP_IDX_VH1: reg_sel = {2'b11, `TCP_KIND_HI};
            `TCP_IDX_VL1: reg_sel = {2'b11, `TCP_KIND_LO};
            default:      reg_sel = 4'h0;
         endcase
      end
   endfunction

   assign pin_in = {channel1_pin_in, channel0_pin_in};
   assign link   = ctl[0][`TCP_CS_MSB];

   // Write channel
   assign wr_go = aw_held && w_held && !s_axi_bvalid;
   assign wsel  = reg_sel(aw_addr);

   always_comb begin
      next_aw_held = aw_held;
      next_w_held  = w_held;
      next_bvalid  = s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
      end
      if (wr_go) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (s_axi_rvalid) begin
         next_rvalid = !s_axi_rready;
      end else begin
         next_rvalid = s_axi_arvalid && s_axi_arready;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `TCP_RESP_OKAY;
      end else begin
         aw_held       <= next_aw_held;
         w_held        <= next_w_held;
         s_axi_awready <= !next_aw_held && !next_bvalid;
         s_axi_wready  <= !next_w_held && !next_bvalid;
         s_axi_bvalid  <= next_bvalid;
         if (wr_go) begin
            s_axi_bresp <= wsel[3] ? `TCP_RESP_OKAY : `TCP_RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_addr <= 8'h00;
         w_data  <= 8'h00;
         w_lane0 <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data  <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
         end
      end
   end

   // Read channel
   assign rsel = reg_sel(s_axi_araddr);

   always_comb begin
      case (rsel[1:0])
         `TCP_KIND_CS: rd_byte = ctl[rsel[2]];
         `TCP_KIND_HI: rd_byte = val[rsel[2]][15:8];
         `TCP_KIND_LO: rd_byte = val[rsel[2]][7:0];
         default:      rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `TCP_RESP_OKAY;
      end else begin
         s_axi_arready <= !next_rvalid;
         s_axi_rvalid  <= next_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rdata <= {24'h00_0000, rsel[3] ? rd_byte : 8'h00};
            s_axi_rresp <= rsel[3] ? `TCP_RESP_OKAY : `TCP_RESP_SLVERR;
         end
      end
   end

   // Per-channel registers and channel logic
   for (genvar i = 0; i < 2; i++) begin : g_ch
      logic wr_cs;
      logic gate;

      assign wr_cs = wr_go && wsel[3] && wsel[2] == i && w_lane0
                     && wsel[1:0] == `TCP_KIND_CS;
      assign val_wr[i] = wr_go && wsel[3] && wsel[2] == i && w_lane0
                         && wsel[1:0] != `TCP_KIND_CS;
      // Channel 1 is silenced while paired
      assign gate = i == 1 && link;

      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            ctl[i] <= `TCP_CS_RESET;
         end else begin
            if (wr_cs) begin
               ctl[i][6:0] <= w_data[6:0]
                  & (i == 0 ? `TCP_CS_WMASK0 : `TCP_CS_WMASK1);
               if (!w_data[`TCP_CS_FLAG]) begin
                  ctl[i][`TCP_CS_FLAG] <= 1'b0;
               end
            end
            // Event set wins over a same-cycle clear
            if (cap_evt[i] || cmp_evt[i]) begin
               ctl[i][`TCP_CS_FLAG] <= 1'b1;
            end
         end
      end

      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            val[i] <= `TCP_VAL_RESET;
         end else if (cap_evt[i]) begin
            val[i] <= cap_val[i];
         end else if (val_wr[i] && wsel[1:0] == `TCP_KIND_HI) begin
            val[i][15:8] <= w_data;
         end else if (val_wr[i]) begin
            val[i][7:0] <= w_data;
         end
      end

      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            chan_req[i] <= 1'b0;
         end else begin
            chan_req[i] <= ctl[i][`TCP_CS_FLAG] && ctl[i][`TCP_CS_IE];
         end
      end

      assign cmp[i] = (i == 0 && link && src_active) ? val[1] : val[i];

      tcp_chan u_chan (
         .aclk               (aclk),
         .aresetn            (aresetn),
         .mode_select_b      (ctl[i][`TCP_CS_MSB] && !gate),
         .mode_select_a      (ctl[i][`TCP_CS_MSA] && !gate),
         .edge_level_select  (gate ? 2'h0
                              : ctl[i][`TCP_CS_ELSH:`TCP_CS_ELSL]),
         .toggle_on_overflow (ctl[i][`TCP_CS_TGLOVF] && !gate),
         .force_full_duty    (ctl[i][`TCP_CS_MAX] && !gate),
         .cmp_val            (cmp[i]),
         .cnt                (tmr_count),
         .ovf                (tmr_overflow),
         .pin_in             (pin_in[i]),
         .pin_out            (pin_out[i]),
         .pin_oe_n           (pin_oe_n[i]),
         .cap_evt            (cap_evt[i]),
         .cap_val            (cap_val[i]),
         .cmp_evt            (cmp_evt[i])
      );
   end

   assign channel0_pin_out  = pin_out[0];
   assign channel0_pin_oe_n = pin_oe_n[0];
   assign channel1_pin_out  = pin_out[1];
   assign channel1_pin_oe_n = pin_oe_n[1];

   // Buffered pair: source follows the last written set
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         link_q      <= 1'b0;
         src_active  <= 1'b0;
         src_pending <= 1'b0;
      end else begin
         link_q <= link;
         if (link && !link_q) begin
            src_active  <= 1'b0;
            src_pending <= 1'b0;
         end else begin
            if (val_wr[1]) begin
               src_pending <= 1'b1;
            end else if (val_wr[0]) begin
               src_pending <= 1'b0;
            end
            if (tmr_overflow) begin
               src_active <= val_wr[1] | (src_pending & !val_wr[0]);
            end
         end
      end
   end

   AST_LINK_START: assert property (@(posedge aclk) disable iff (!aresetn)
      link && !link_q |=> !src_active)
      else $error("paired channels did not start on channel 0");

   AST_CH1_WAITS: assert property (@(posedge aclk) disable iff (!aresetn)
      link && link_q && val_wr[1] && !tmr_overflow
      |=> src_pending && src_active == $past(src_active))
      else $error("channel 1 write took effect mid-period");

   AST_BUF_SEL: assert property (@(posedge aclk) disable iff (!aresetn)
      link && link_q && tmr_overflow && !val_wr[0] && !val_wr[1]
      |=> src_active == $past(src_pending))
      else $error("overflow picked the wrong register set");

   AST_CH1_QUIET: assert property (@(posedge aclk) disable iff (!aresetn)
      link |=> channel1_pin_oe_n)
      else $error("channel 1 pin driven while paired");

   AST_FLAG_SET: assert property (@(posedge aclk) disable iff (!aresetn)
      cmp_evt[0] |=> ctl[0][`TCP_CS_FLAG])
      else $error("compare event lost");

   COV_BUF_SWAP: cover property (@(posedge aclk) disable iff (!aresetn)
      link && src_active ##1 !src_active);
   COV_WRITE: cover property (@(posedge aclk) disable iff (!aresetn)
      s_axi_bvalid && s_axi_bready);

endmodule

// ==== tb/tcp_pin_model.sv ====
// Outside circuit model driving the two channel pins
`timescale 1ns/10ps

module tcp_pin_model (
   // Levels wanted by the bench
   input  wire logic [1:0] lvl,
   // Block side of the pins
   input  wire logic       out0,
   input  wire logic       oe0_n,
   input  wire logic       out1,
   input  wire logic       oe1_n,
   // Wire levels
   output      logic       pin0,
   output      logic       pin1
);
   // Wire follows the block while it drives
   assign pin0 = oe0_n ? lvl[0] : out0;
   assign pin1 = oe1_n ? lvl[1] : out1;
endmodule

// ==== tb/test_timer_channel_capture_pwm.sv ====
// Self-checking bench for the timer channel pair
`timescale 1ns/10ps
`include "tcp_consts.svh"

module test_timer_channel_capture_pwm;
   logic        aclk, aresetn, run;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic        awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, chan_req, lvl;
   logic [15:0] tmr_count;
   logic [3:0]  wstrb;
   logic [1:0]  bresp_seen;
   logic        ovf, pin0, pin1, out0, oe0_n, out1, oe1_n;
   int          mismatches, check_count, cyc;

   tcp_top tcp_top_inst (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .tmr_count(tmr_count),
      .tmr_overflow(ovf), .channel0_pin_in(pin0),
      .channel0_pin_out(out0), .channel0_pin_oe_n(oe0_n),
      .channel1_pin_in(pin1), .channel1_pin_out(out1),
      .channel1_pin_oe_n(oe1_n), .chan_req(chan_req)
   );

   tcp_pin_model tcp_pin_model_inst (
      .lvl(lvl), .out0(out0), .oe0_n(oe0_n), .out1(out1),
      .oe1_n(oe1_n), .pin0(pin0), .pin1(pin1)
   );

   always #25 aclk = ~aclk;
   // Period of 16 counts, overflow at count zero
   assign ovf = run & (tmr_count == 16'h0000);
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (run)
         tmr_count <= (tmr_count == 16'h000f) ? 16'h0 : tmr_count + 16'h1;
      if (cyc == 20000) begin
         mismatches++;
         summarize();
      end
   end

   task summarize;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] got, exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic axw(input logic [5:0] i, input logic [7:0] d);
      @(posedge aclk);
      awaddr <= {i, 2'h0};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bresp_seen = bresp;
      bready <= 1'b0;
   endtask

   task automatic axr(input logic [5:0] i, input logic [7:0] e,
                      input logic [1:0] r);
      @(posedge aclk);
      araddr <= {i, 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready)
            arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk("rdata", rdata, {24'h0, e});
      chk("rresp", {30'h0, rresp}, {30'h0, r});
   endtask

   // Wait until the counter shows k, just after the edge
   task automatic at(input logic [15:0] k);
      int n;
      n = 0;
      do begin
         @(posedge aclk);
         #1;
         n++;
      end while (tmr_count !== k && n < 40);
      chk("at", {16'h0, tmr_count}, {16'h0, k});
   endtask

   task s_reset;
      chk("oe0", {31'h0, oe0_n}, 32'h1);
      chk("out0", {31'h0, out0}, 32'h1);
      axr(`TCP_IDX_CS0, 8'h00, `TCP_RESP_OKAY);
      axr(`TCP_IDX_VH1, 8'h00, `TCP_RESP_OKAY);
      axr(6'h30, 8'h00, `TCP_RESP_SLVERR);
      chk("out1", {31'h0, out1}, 32'h1);
      wstrb <= 4'h0;
      axw(`TCP_IDX_CS0, 8'h55);
      wstrb <= 4'h1;
      chk("bresp_ns", {30'h0, bresp_seen}, {30'h0, `TCP_RESP_OKAY});
      axr(`TCP_IDX_CS0, 8'h00, `TCP_RESP_OKAY);
      axw(6'h30, 8'h55);
      chk("bresp_err", {30'h0, bresp_seen}, {30'h0, `TCP_RESP_SLVERR});
      axw(`TCP_IDX_CS0, 8'h10);
      chk("bresp_ok", {30'h0, bresp_seen}, {30'h0, `TCP_RESP_OKAY});
      repeat (3) @(posedge aclk);
      #1;
      chk("preset", {31'h0, out0}, 32'h0);
      chk("oe0p", {31'h0, oe0_n}, 32'h1);
   endtask

   task s_capture;
      for (int c = 1; c < 4; c++) begin
         axw(`TCP_IDX_CS0, {4'h0, c[1:0], 2'h0});
         @(posedge aclk);
         tmr_count <= 16'h1230 + 16'(c);
         lvl[0] <= 1'b1;
         repeat (4) @(posedge aclk);
         axr(`TCP_IDX_CS0, {c[0], 3'h0, c[1:0], 2'h0}, 2'h0);
         axw(`TCP_IDX_CS0, {4'h0, c[1:0], 2'h0});
         lvl[0] <= 1'b0;
         repeat (4) @(posedge aclk);
         axr(`TCP_IDX_CS0, {c[1], 3'h0, c[1:0], 2'h0}, 2'h0);
      end
      axr(`TCP_IDX_VH0, 8'h12, `TCP_RESP_OKAY);
      axr(`TCP_IDX_VL0, 8'h33, `TCP_RESP_OKAY);
   endtask

   task s_pwm;
      axw(`TCP_IDX_VH0, 8'h00);
      axw(`TCP_IDX_VL0, 8'h05);
      axw(`TCP_IDX_CS0, 8'h58);
      at(16'h000f);
      at(16'h0003);
      chk("pwm_hi", {31'h0, out0}, 32'h1);
      at(16'h0008);
      chk("pwm_lo", {31'h0, out0}, 32'h0);
      chk("req", {30'h0, chan_req}, 32'h1);
      axr(`TCP_IDX_CS0, 8'hd8, `TCP_RESP_OKAY);
   endtask

   task s_tov;
      logic p;
      axw(`TCP_IDX_VL0, 8'h00);
      axw(`TCP_IDX_CS0, 8'h1a);
      at(16'h000f);
      at(16'h0008);
      p = out0;
      at(16'h0008);
      chk("tov", {31'h0, out0}, {31'h0, ~p});
   endtask

   task s_max;
      at(16'h0001);
      axw(`TCP_IDX_VL0, 8'h05);
      axw(`TCP_IDX_CS0, 8'h18);
      at(16'h0007);
      axw(`TCP_IDX_CS0, 8'h19);
      at(16'h000e);
      chk("max_late", {31'h0, out0}, 32'h0);
      at(16'h0008);
      chk("max_on", {31'h0, out0}, 32'h1);
      axw(`TCP_IDX_CS0, 8'h18);
      at(16'h000e);
      chk("max_hold", {31'h0, out0}, 32'h1);
      at(16'h0008);
      chk("max_off", {31'h0, out0}, 32'h0);
   endtask

   task s_buf;
      axw(`TCP_IDX_VL0, 8'h03);
      axw(`TCP_IDX_CS0, 8'h38);
      at(16'h000f);
      at(16'h0005);
      chk("buf0", {31'h0, out0}, 32'h0);
      chk("oe1", {31'h0, oe1_n}, 32'h1);
      axw(`TCP_IDX_VL1, 8'h08);
      at(16'h0005);
      chk("buf1", {31'h0, out0}, 32'h1);
      at(16'h000a);
      chk("buf1e", {31'h0, out0}, 32'h0);
      axw(`TCP_IDX_VL0, 8'h03);
      at(16'h0005);
      chk("buf0b", {31'h0, out0}, 32'h0);
   endtask

   task s_codes;
      logic p;
      axw(`TCP_IDX_CS0, 8'h1c);
      at(16'h000f);
      at(16'h0002);
      chk("set_lo", {31'h0, out0}, 32'h0);
      at(16'h0005);
      chk("set_hi", {31'h0, out0}, 32'h1);
      axw(`TCP_IDX_CS0, 8'h14);
      at(16'h0005);
      p = out0;
      at(16'h0005);
      chk("tgl", {31'h0, out0}, {31'h0, ~p});
   endtask

   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      run = 1'b0;
      {awaddr, araddr, wdata, lvl, tmr_count} = '0;
      wstrb = 4'h1;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      {mismatches, check_count, cyc} = '0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      #1;
      s_reset();
      s_capture();
      @(posedge aclk);
      tmr_count <= 16'h0000;
      run <= 1'b1;
      s_pwm();
      s_tov();
      s_max();
      s_buf();
      s_codes();
      summarize();
   end
endmodule
